// file: pkg/sdi12_responder_cfg.svh
// constants for the sdi12 sensor command responder
`ifndef SDI12_RESPONDER_CFG_SVH
`define SDI12_RESPONDER_CFG_SVH

`define SR_NUM_VALUES   9
`define SR_NUM_MEASURED 7
`define SR_NUM_DIGITS   8
`define SR_CMD_MAX      4
`define SR_MEAS_SECONDS 1
`define SR_MEAS_COUNT   9
`define SR_IDENT_LAST   26
`define SR_CRC_INIT     16'h0000
`define SR_CRC_POLY     16'hA001

`define SR_DEC_IRRADIANCE 1
`define SR_DEC_VOLTAGE    4
`define SR_DEC_SENSTEMP   2
`define SR_DEC_TILT       1
`define SR_DEC_BODYTEMP   1
`define SR_DEC_HUMIDITY   1
`define SR_DEC_FLAG       0

`define SR_CH_ZERO  8'h30
`define SR_CH_NINE  8'h39
`define SR_CH_FOUR  8'h34
`define SR_CH_LA    8'h61
`define SR_CH_LZ    8'h7A
`define SR_CH_UA    8'h41
`define SR_CH_UZ    8'h5A
`define SR_CH_M     8'h4D
`define SR_CH_C     8'h43
`define SR_CH_R     8'h52
`define SR_CH_D     8'h44
`define SR_CH_I     8'h49
`define SR_CH_QUERY 8'h3F
`define SR_CH_BANG  8'h21
`define SR_CH_PLUS  8'h2B
`define SR_CH_MINUS 8'h2D
`define SR_CH_DOT   8'h2E
`define SR_CH_CR    8'h0D
`define SR_CH_LF    8'h0A
`define SR_CRC_CHAR 8'h40

`endif

// file: pkg/sdi12_responder_pkg.sv
// types for the sdi12 sensor command responder
package sdi12_responder_pkg;

  typedef struct packed {
    logic            neg;
    logic [7:0][3:0] bcd;
  } value_t;

  typedef struct packed {
    value_t [6:0] vals;
    logic         humAlarm;
    logic         heatAlarm;
  } sensor_vals_t;

  typedef enum logic [5:0] {
    PH_IDLE = 6'h01,
    PH_ADDR = 6'h02,
    PH_BODY = 6'h04,
    PH_CRC  = 6'h08,
    PH_CR   = 6'h10,
    PH_LF   = 6'h20
  } phase_t;

  typedef enum logic [4:0] {
    K_ADDR  = 5'h01,
    K_MEAS  = 5'h02,
    K_CMEAS = 5'h04,
    K_IDENT = 5'h08,
    K_DATA  = 5'h10
  } kind_t;

  typedef struct packed {
    phase_t          phase;
    kind_t           kind;
    logic            inCmd;
    logic            ovf;
    logic [7:0]      rxAddr;
    logic [3:0][7:0] body;
    logic [2:0]      len;
    logic [7:0]      respAddr;
    logic            crcMode;
    logic            addCrc;
    logic            srPending;
    logic            srReady;
    logic [3:0]      valIdx;
    logic [3:0]      valLast;
    logic [3:0]      digPos;
    logic            started;
    logic            dotDone;
    logic [4:0]      txtIdx;
    logic [1:0]      crcIdx;
    logic [15:0]     crc;
    logic            txValid;
    logic [7:0]      txData;
    logic            measStart;
  } state_t;

endpackage

// file: src/sdi12_sensor_command_responder.sv
// sdi12 sensor command interpreter: parses addressed commands, sends framed responses
`timescale 1ns/100ps
`include "sdi12_responder_cfg.svh"
// What this block does
// - any measure request M, C, MC, CC, R0, RC0 with own address is acted on
// - crc variants append a three character crc to the data responses
// - continuous read returns all current values in one response, no start step
// - first data request gives irradiance with one decimal
// - second gives output voltage, four decimals, and sensor temperature, two decimals
// - third gives x and y tilt angles, one decimal each, signed
// - fourth gives body temperature and enclosure humidity, one decimal each
// - fifth gives humidity and dome heating flags, zero normal, one abnormal
// - identify answer: address, version 14, company, model, version, serial
// - address query answers with the configured address, or with 0 when that is not a valid address
// - every response ends with carriage return then line feed
// - address is one character 0-9, a-z or A-Z
module sdi12_sensor_command_responder
  import sdi12_responder_pkg::*;
#(
  parameter logic [9:0]  MEAS_SECONDS = 10'(`SR_MEAS_SECONDS),
  parameter logic [63:0] COMPANY      = 64'h5645_4E44_4F52_5858, // arbitrary
  parameter logic [47:0] MODEL        = 48'h4D4F_4445_4C31,      // arbitrary
  parameter logic [23:0] SENS_VER     = 24'h3130_30,             // arbitrary
  parameter logic [63:0] SERIAL       = 64'h3030_3030_3030_3031  // arbitrary
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic [7:0]   addrCfg,
  input  wire logic         rxValid,
  input  wire logic [7:0]   rxData,
  output logic              txValid,
  output logic [7:0]        txData,
  input  wire logic         txReady,
  output logic              measStart,
  input  wire logic         measDone,
  input  wire sensor_vals_t sensorVals
);

  localparam logic [215:0] IDENT = {`SR_CH_ZERO + 8'h01, `SR_CH_FOUR,
                                    COMPANY, MODEL, SENS_VER, SERIAL};
  localparam logic [3:0] DEC [`SR_NUM_VALUES] = '{
    4'(`SR_DEC_IRRADIANCE), 4'(`SR_DEC_VOLTAGE), 4'(`SR_DEC_SENSTEMP),
    4'(`SR_DEC_TILT), 4'(`SR_DEC_TILT), 4'(`SR_DEC_BODYTEMP),
    4'(`SR_DEC_HUMIDITY), 4'(`SR_DEC_FLAG), 4'(`SR_DEC_FLAG)};
  localparam logic [3:0] T_HUND = 4'(MEAS_SECONDS / 100);
  localparam logic [3:0] T_TENS = 4'((MEAS_SECONDS / 10) % 10);
  localparam logic [3:0] T_ONES = 4'(MEAS_SECONDS % 10);
  localparam logic [3:0] N_COUNT = 4'(`SR_MEAS_COUNT);

  state_t s;
  state_t n;
  value_t allVals [`SR_NUM_VALUES];

  genvar g;
  generate
    for (g = 0; g < `SR_NUM_MEASURED; g++) begin : gVals
      assign allVals[g] = sensorVals.vals[g];
    end
  endgenerate
  assign allVals[7] = '{neg: 1'b0, bcd: {28'h0, 3'h0, sensorVals.humAlarm}};
  assign allVals[8] = '{neg: 1'b0, bcd: {28'h0, 3'h0, sensorVals.heatAlarm}};

  function automatic logic validAddr(input logic [7:0] c);
    validAddr = (c >= `SR_CH_ZERO && c <= `SR_CH_NINE) ||
                (c >= `SR_CH_LA && c <= `SR_CH_LZ) ||
                (c >= `SR_CH_UA && c <= `SR_CH_UZ);
  endfunction

  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ `SR_CRC_POLY) : (r >> 1);
    end
    crcByte = r;
  endfunction

  function automatic state_t startResp(input state_t st, input kind_t k,
                                       input logic [7:0] a, input logic [3:0] first,
                                       input logic [3:0] last, input logic withCrc);
    state_t r;
    r          = st;
    r.phase    = PH_ADDR;
    r.kind     = k;
    r.respAddr = a;
    r.valIdx   = first;
    r.valLast  = last;
    r.addCrc   = withCrc;
    r.digPos   = 4'h0;
    r.started  = 1'b0;
    r.dotDone  = 1'b0;
    r.txtIdx   = 5'h00;
    r.crcIdx   = 2'h0;
    r.crc      = `SR_CRC_INIT;
    startResp  = r;
  endfunction

  logic [7:0] ownAddr;
  assign ownAddr = validAddr(addrCfg) ? addrCfg : `SR_CH_ZERO;

  logic       adv;
  logic       emit;
  logic [7:0] eByte;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [2:0] dn;
  value_t     cur;
  logic [3:0] curDec;
  logic [3:0] intN;
  logic [2:0] di;
  logic [3:0] dig;
  logic       lastTxt;

  assign adv = !s.txValid || txReady;
  assign b0  = s.body[0];
  assign b1  = s.body[1];
  assign b2  = s.body[2];
  assign dn  = 3'(b1 - `SR_CH_ZERO);

  always_comb begin
    n           = s;
    n.measStart = 1'b0;
    emit        = 1'b0;
    eByte       = 8'h00;
    cur         = allVals[s.valIdx];
    curDec      = DEC[s.valIdx];
    intN        = 4'(`SR_NUM_DIGITS) - curDec;
    di          = 3'(s.digPos - 4'h1);
    dig         = cur.bcd[3'h7 - di];
    lastTxt     = 1'b0;
    if (measDone && s.srPending) begin
      n.srReady   = 1'b1;
      n.srPending = 1'b0;
    end
    case (s.phase)
      PH_IDLE: begin
        if (s.srReady && !s.inCmd && !rxValid) begin
          n         = startResp(n, K_ADDR, ownAddr, 4'h0, 4'h0, 1'b0);
          n.srReady = 1'b0;
        end else if (rxValid) begin
          if (!s.inCmd) begin
            n.inCmd  = 1'b1;
            n.rxAddr = rxData;
            n.len    = 3'h0;
            n.ovf    = 1'b0;
          end else if (rxData != `SR_CH_BANG) begin
            if (s.len == 3'(`SR_CMD_MAX)) begin
              n.ovf = 1'b1;
            end else begin
              n.body[s.len[1:0]] = rxData;
              n.len              = s.len + 3'h1;
            end
          end else begin
            n.inCmd = 1'b0;
            if (s.ovf) begin
              n.inCmd = 1'b0;
            end else if (s.rxAddr == `SR_CH_QUERY && s.len == 3'h0) begin
              n = startResp(n, K_ADDR, ownAddr, 4'h0, 4'h0, 1'b0);
            end else if (s.rxAddr == ownAddr) begin
              if (s.len == 3'h0) begin
                n = startResp(n, K_ADDR, ownAddr, 4'h0, 4'h0, 1'b0);
              end else if (s.len == 3'h1 && b0 == `SR_CH_I) begin
                n = startResp(n, K_IDENT, ownAddr, 4'h0, 4'h0, 1'b0);
              end else if ((s.len == 3'h1 || (s.len == 3'h2 && b1 == `SR_CH_C)) &&
                           (b0 == `SR_CH_M || b0 == `SR_CH_C)) begin
                n = startResp(n, (b0 == `SR_CH_M) ? K_MEAS : K_CMEAS,
                              ownAddr, 4'h0, 4'h0, 1'b0);
                n.crcMode   = (s.len == 3'h2);
                n.measStart = 1'b1;
                n.srPending = (b0 == `SR_CH_M);
                n.srReady   = 1'b0;
              end else if (b0 == `SR_CH_R && ((s.len == 3'h2 && b1 == `SR_CH_ZERO) ||
                           (s.len == 3'h3 && b1 == `SR_CH_C && b2 == `SR_CH_ZERO))) begin
                n = startResp(n, K_DATA, ownAddr, 4'h0, 4'(`SR_NUM_VALUES - 1),
                              s.len == 3'h3);
              end else if (s.len == 3'h2 && b0 == `SR_CH_D &&
                           b1 >= `SR_CH_ZERO && b1 <= `SR_CH_FOUR) begin
                n = startResp(n, K_DATA, ownAddr,
                              (dn == 3'h0) ? 4'h0 : 4'({dn, 1'b0} - 4'h1),
                              4'({dn, 1'b0}), s.crcMode);
              end
            end
          end
        end
      end
      PH_ADDR: begin
        if (adv) begin
          emit    = 1'b1;
          eByte   = s.respAddr;
          n.phase = (s.kind != K_ADDR) ? PH_BODY : PH_CR;
        end
      end
      PH_BODY: begin
        if (adv) begin
          case (s.kind)
            K_MEAS, K_CMEAS: begin
              emit = 1'b1;
              case (s.txtIdx)
                5'h00:   eByte = `SR_CH_ZERO + {4'h0, T_HUND};
                5'h01:   eByte = `SR_CH_ZERO + {4'h0, T_TENS};
                5'h02:   eByte = `SR_CH_ZERO + {4'h0, T_ONES};
                5'h03:   eByte = (s.kind == K_CMEAS) ? `SR_CH_ZERO
                                                     : `SR_CH_ZERO + {4'h0, N_COUNT};
                default: eByte = `SR_CH_ZERO + {4'h0, N_COUNT};
              endcase
              lastTxt = (s.kind == K_MEAS) ? (s.txtIdx == 5'h03) : (s.txtIdx == 5'h04);
            end
            K_IDENT: begin
              emit    = 1'b1;
              eByte   = IDENT[8'd215 - {s.txtIdx, 3'h0} -: 8];
              lastTxt = (s.txtIdx == 5'(`SR_IDENT_LAST));
            end
            K_DATA: begin
              if (s.digPos == 4'h0) begin
                emit     = 1'b1;
                eByte    = cur.neg ? `SR_CH_MINUS : `SR_CH_PLUS;
                n.digPos = 4'h1;
              end else if ({1'b0, di} == intN && !s.dotDone && curDec != 4'h0) begin
                emit      = 1'b1;
                eByte     = `SR_CH_DOT;
                n.dotDone = 1'b1;
              end else begin
                if ({1'b0, di} >= intN - 4'h1 || dig != 4'h0 || s.started) begin
                  emit      = 1'b1;
                  eByte     = `SR_CH_ZERO + {4'h0, dig};
                  n.started = 1'b1;
                end
                if (di == 3'h7) begin
                  if (s.valIdx == s.valLast) begin
                    n.phase = s.addCrc ? PH_CRC : PH_CR;
                  end else begin
                    n.valIdx  = s.valIdx + 4'h1;
                    n.digPos  = 4'h0;
                    n.started = 1'b0;
                    n.dotDone = 1'b0;
                  end
                end else begin
                  n.digPos = s.digPos + 4'h1;
                end
              end
            end
            default: n.phase = PH_CR;
          endcase
          if (s.kind != K_DATA) begin
            n.txtIdx = s.txtIdx + 5'h01;
            if (lastTxt) begin
              n.phase = PH_CR;
            end
          end
        end
      end
      PH_CRC: begin
        if (adv) begin
          emit = 1'b1;
          case (s.crcIdx)
            2'h0:    eByte = `SR_CRC_CHAR | {4'h0, s.crc[15:12]};
            2'h1:    eByte = `SR_CRC_CHAR | {2'h0, s.crc[11:6]};
            default: eByte = `SR_CRC_CHAR | {2'h0, s.crc[5:0]};
          endcase
          n.crcIdx = s.crcIdx + 2'h1;
          if (s.crcIdx == 2'h2) begin
            n.phase = PH_CR;
          end
        end
      end
      PH_CR: begin
        if (adv) begin
          emit    = 1'b1;
          eByte   = `SR_CH_CR;
          n.phase = PH_LF;
        end
      end
      PH_LF: begin
        if (adv) begin
          emit    = 1'b1;
          eByte   = `SR_CH_LF;
          n.phase = PH_IDLE;
        end
      end
      default: n.phase = PH_IDLE;
    endcase
    if (adv) begin
      n.txValid = emit;
      if (emit) begin
        n.txData = eByte;
      end
      if (emit && (s.phase == PH_ADDR || s.phase == PH_BODY)) begin
        n.crc = crcByte(s.crc, eByte);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s       <= '0;
      s.phase <= PH_IDLE;
      s.kind  <= K_ADDR;
    end else if (ce) begin
      s <= n;
    end
  end

  assign txValid   = s.txValid;
  assign txData    = s.txData;
  assign measStart = s.measStart;

endmodule // sdi12_sensor_command_responder

// file: test/sdi12_responder_assertions.sv
// port assertions for the sdi12 sensor command responder
`timescale 1ns/100ps
module sdi12_responder_assertions
  import sdi12_responder_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         resetn,
  input wire logic         ce,
  input wire logic [7:0]   addrCfg,
  input wire logic         rxValid,
  input wire logic [7:0]   rxData,
  input wire logic         txValid,
  input wire logic [7:0]   txData,
  input wire logic         txReady,
  input wire logic         measStart,
  input wire logic         measDone,
  input wire sensor_vals_t sensorVals
);
  logic       busyQ;
  logic [7:0] expAddr;
  assign expAddr = ((addrCfg >= 8'h30 && addrCfg <= 8'h39) || (addrCfg >= 8'h61 &&
    addrCfg <= 8'h7A) || (addrCfg >= 8'h41 && addrCfg <= 8'h5A)) ? addrCfg : 8'h30;
  // high between the first taken byte of a response and its line feed
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) busyQ <= 1'b0;
    else if (ce && txValid && txReady) busyQ <= (txData != 8'h0A);
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn || !ce);
  a_tx_hold:
    assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("response byte changed before it was taken");
  a_lf_follows:
    assert property (txValid && txReady && txData == 8'h0D |=> txValid && txData == 8'h0A)
    else $error("carriage return not followed by line feed");
  a_idle_after:
    assert property (txValid && txReady && txData == 8'h0A |=> !txValid)
    else $error("output still valid after line feed");
  a_first_addr:
    assert property (txValid && !busyQ |-> txData == expAddr)
    else $error("response does not open with own address");
  a_meas_addr:
    assert property (measStart |-> ##[0:1] (txValid && !busyQ && txData == expAddr))
    else $error("measure start without a response");
  a_meas_pulse:
    assert property (measStart |=> !measStart)
    else $error("measure start longer than one cycle");
  a_gap_bound:
    assert property (busyQ && !txValid |-> ##[1:20] txValid)
    else $error("response stalled in mid stream");
  a_char_range:
    assert property (txValid |-> txData inside {8'h0D, 8'h0A} || txData inside {[8'h20:8'h7F]})
    else $error("response byte outside printable set");
endmodule  // sdi12_responder_assertions

bind sdi12_sensor_command_responder sdi12_responder_assertions sdi12_responder_assertions_inst (
  .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .addrCfg(addrCfg), .rxValid(rxValid),
  .rxData(rxData), .txValid(txValid), .txData(txData), .txReady(txReady),
  .measStart(measStart), .measDone(measDone), .sensorVals(sensorVals));

// file: test/sdi12_logger_model.sv
// data logger model: sends commands, retries, records response bytes
`timescale 1ns/100ps
module sdi12_logger_model (
  input  wire logic       sys_clk,
  output logic            rxValid,
  output logic [7:0]      rxData,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady,
  input  wire logic       slow
);
  logic [7:0] resp[$];
  initial begin
    rxValid = 1'b0;
    rxData  = 8'h00;
    txReady = 1'b1;
  end
  // take bytes on the edge, then move ready; slow mode stalls every other cycle
  always @(posedge sys_clk) begin
    if (txValid && txReady) resp.push_back(txData);
    #1 txReady = !slow || !txReady;
  end
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge sys_clk);
      #1 rxValid = 1'b1;
      rxData = s[i];
      @(posedge sys_clk);
      #1 rxValid = 1'b0;
      rxData = ~rxData;
    end
  endtask
  // block until a line feed arrives or the timeout runs out
  task automatic listen(input int limit);
    repeat (limit) begin
      @(posedge sys_clk);
      #2;
      if (resp.size() > 0 && resp[$] === 8'h0A) return;
    end
  endtask
  // three attempts of three tries, stop at the first answer
  task automatic query(input string s);
    for (int n = 0; n < 9; n++) begin
      resp.delete();
      send(s);
      listen(150);
      if (resp.size() > 0) return;
    end
  endtask
endmodule  // sdi12_logger_model

// file: test/test_sdi12_sensor_command_responder.sv
// self-checking bench for the sdi12 sensor command responder
`timescale 1ns/100ps
module test_sdi12_sensor_command_responder
  import sdi12_responder_pkg::*;
  ;
  logic         sys_clk;
  logic         resetn;
  logic [7:0]   addrCfg;
  logic         rxValid;
  logic [7:0]   rxData;
  logic         txValid;
  logic [7:0]   txData;
  logic         txReady;
  logic         measStart;
  logic         measDone;
  logic         slow;
  logic         ce;
  sensor_vals_t sensorVals;
  int           fail_count;
  int           samples_checked;
  int           measCount;
  string        vals;
  string        cmds[13];
  string        exps[13];

  sdi12_sensor_command_responder #(.MEAS_SECONDS(10'd2), .COMPANY("ABCDEFGH"),
    .MODEL("MODEL2"), .SENS_VER("001"), .SERIAL("00000042")) sdi12_sensor_command_responder_inst (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .addrCfg(addrCfg), .rxValid(rxValid),
    .rxData(rxData), .txValid(txValid), .txData(txData), .txReady(txReady),
    .measStart(measStart), .measDone(measDone), .sensorVals(sensorVals));
  sdi12_logger_model logger_model_inst (.sys_clk(sys_clk), .rxValid(rxValid), .rxData(rxData),
    .txValid(txValid), .txData(txData), .txReady(txReady), .slow(slow));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (measStart === 1'b1) measCount++;

  function automatic string crc3(input string s);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < s.len(); i++) begin
      c ^= {8'h00, s[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return $sformatf("%c%c%c", 8'h40 | c[15:12], 8'h40 | c[11:6], 8'h40 | c[5:0]);
  endfunction

  task automatic cmp_resp(input string name, input string e);
    logic [7:0] ev;
    logic [7:0] sv;
    samples_checked++;
    for (int i = 0; i < e.len() || i < logger_model_inst.resp.size(); i++) begin
      ev = (i < e.len()) ? e[i] : 8'hFF;
      sv = (i < logger_model_inst.resp.size()) ? logger_model_inst.resp[i] : 8'hFF;
      if (sv !== ev) begin
        fail_count++;
        $display("BAD %s byte %0d expected %h seen %h", name, i, ev, sv);
        return;
      end
    end
  endtask
  task automatic cmp_val(input string name, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", name, e, s);
    end
  endtask
  task automatic run(input string c, input string e);
    logger_model_inst.query(c);
    cmp_resp(c, e);
    $display("test %s done", c);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    $display("BAD watchdog expected finish seen hang");
    stop_test();
  end

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    addrCfg = 8'h30;
    measDone = 1'b0;
    slow = 1'b0;
    sensorVals.vals[0] = {1'b0, 32'h00001234};
    sensorVals.vals[1] = {1'b0, 32'h00012345};
    sensorVals.vals[2] = {1'b1, 32'h00002550};
    sensorVals.vals[3] = {1'b0, 32'h00000015};
    sensorVals.vals[4] = {1'b1, 32'h00000003};
    sensorVals.vals[5] = {1'b0, 32'h00000312};
    sensorVals.vals[6] = {1'b0, 32'h00000450};
    sensorVals.humAlarm = 1'b1;
    sensorVals.heatAlarm = 1'b0;
    vals = "+123.4+1.2345-25.50+1.5-0.3+31.2+45.0+1+0";
    cmds = '{"0!", "?!", "0I!", "0C!", "0D0!", "0D1!", "0D2!", "0D3!", "0D4!", "0R0!",
             "1!", "0D5!", "0X!"};
    exps = '{"0", "0", "014ABCDEFGHMODEL200100000042", "000209", "0+123.4", "0+1.2345-25.50",
             "0+1.5-0.3", "0+31.2+45.0", "0+1+0", {"0", vals}, "", "", ""};
    // rows
    repeat (2) @(posedge sys_clk);
    #1 resetn = 1'b1;
    cmp_val("txValid after reset", 0, txValid);
    for (int i = 0; i < 13; i++)
      run(cmds[i], exps[i] == "" ? "" : {exps[i], "\r\n"});
    run("0CC!", "000209\r\n");
    run("0D0!", {"0+123.4", crc3("0+123.4"), "\r\n"});
    run("0C!", "000209\r\n");
    run("0RC0!", {"0", vals, crc3({"0", vals}), "\r\n"});
    run("0MC!", "00029\r\n");
    run("0D4!", {"0+1+0", crc3("0+1+0"), "\r\n"});
    run("0D0000!", "");
    slow = 1'b1;
    run("0M!", "00029\r\n");
    logger_model_inst.resp.delete();
    @(posedge sys_clk);
    #1 measDone = 1'b1;
    @(posedge sys_clk);
    #1 measDone = 1'b0;
    logger_model_inst.listen(300);
    cmp_resp("service request", "0\r\n");
    $display("test service request done");
    run("0D0!", "0+123.4\r\n");
    slow = 1'b0;
    cmp_val("measure starts", 5, measCount);
    addrCfg = 8'h61;
    run("a!", "a\r\n");
    run("0!", "");
    addrCfg = 8'h23;
    run("0!", "0\r\n");
    // clock enable low: a whole command must pass unseen
    @(posedge sys_clk);
    #1 ce = 1'b0;
    run("0!", "");
    cmp_val("txValid while frozen", 0, txValid);
    @(posedge sys_clk);
    #1 ce = 1'b1;
    run("0!", "0\r\n");
    // reset in mid response, then the block must answer afresh
    fork
      logger_model_inst.query("0I!");
      begin
        wait (txValid === 1'b1);
        @(posedge sys_clk);
        #1 resetn = 1'b0;
        @(posedge sys_clk);
        #1 resetn = 1'b1;
        cmp_val("txValid after mid reset", 0, txValid);
      end
    join
    $display("test mid reset done");
    run("0!", "0\r\n");
    stop_test();
  end
endmodule  // test_sdi12_sensor_command_responder
